/* rtl/nsov_pkg.sv */
package nsov_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0]  CTRL_OFS        = 8'h00;
	localparam logic [7:0]  START_PCT_OFS   = 8'h04;
	localparam logic [7:0]  TRIP_DELAY_OFS  = 8'h08;
	localparam logic [7:0]  STATUS_OFS      = 8'h0C;
	localparam logic [7:0]  VOLTAGE_OFS     = 8'h10;

	// Control register fields.
	localparam int          CTRL_ENABLE_BIT = 0;
	localparam int          CTRL_SONLY_BIT  = 1;

	// Status register fields.
	localparam int          ST_START_BIT    = 0;
	localparam int          ST_TRIP_BIT     = 1;
	localparam int          ST_GSTART_BIT   = 2;
	localparam int          ST_GTRIP_BIT    = 3;

	// Setting ranges and reset values.
	localparam logic [7:0]  PCT_MIN         = 8'h02;
	localparam logic [7:0]  PCT_MAX         = 8'h28;
	localparam logic [7:0]  PCT_RESET       = 8'h1E;
	localparam logic [15:0] DELAY_MIN       = 16'h0032;
	localparam logic [15:0] DELAY_MAX       = 16'hEA60;
	localparam logic [15:0] DELAY_RESET     = 16'h0064;
	localparam logic        ENABLE_RESET    = 1'b1;
	localparam logic        SONLY_RESET     = 1'b0;

	// Voltage input carries percent of nominal with this many fraction bits.
	localparam int          VOLT_FRAC_BITS  = 8;

	// Timing: one millisecond at the 250 MHz bus clock.
	localparam int          CLK_PERIOD_PS   = 4000;
	localparam int          MS_TIME_PS      = 1000000000;
	localparam int          MS_TICK_CYCLES  = MS_TIME_PS / CLK_PERIOD_PS;

	typedef struct packed {
		logic        enable;
		logic        start_only;
		logic [7:0]  pct;
		logic [15:0] delay;
	} nsov_cfg_type;

	typedef enum logic [1:0] {
		NSOV_IDLE    = 2'b00,
		NSOV_STARTED = 2'b01,
		NSOV_TRIPPED = 2'b10
	} nsov_state_type;

endpackage

/* rtl/nsov_trip.sv */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module nsov_trip #(
	parameter int MS_TICK_CYCLES = nsov_pkg::MS_TICK_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] neg_seq_voltage,
	input  wire logic        function_block_in,
	output logic             general_start_out,
	output logic             general_trip_out
);

	////////////////////////////////////////////////////////////////////////
	// Range limiting of software settings.
	// Settings outside their range are clamped rather than refused, so a
	// careless write still leaves the function with a usable threshold
	// and delay instead of silently keeping the old value.

	function automatic logic [15:0] clamp16(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	nsov_pkg::nsov_cfg_type  cfg_q;
	nsov_pkg::nsov_state_type state_q;
	nsov_pkg::nsov_state_type state_d;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        gstart_q;
	logic        gtrip_q;
	logic [31:0] tick_cnt_q;
	// The millisecond counter is wide enough for the longest delay.
	logic [15:0] ms_cnt_q;

	////////////////////////////////////////////////////////////////////////
	// APB decode. The slave answers with no wait state: pready is set at
	// the setup edge, so the access phase always completes in one cycle.

	// Only aligned word offsets decode; any other address is unmapped.
	wire         setup_cyc  = psel & ~penable;
	wire         access_cyc = psel & penable & pready_q;
	wire         wr_en      = access_cyc & pwrite;
	wire         hit_ctrl   = (paddr == nsov_pkg::CTRL_OFS);
	wire         hit_pct    = (paddr == nsov_pkg::START_PCT_OFS);
	wire         hit_delay  = (paddr == nsov_pkg::TRIP_DELAY_OFS);
	wire         hit_status = (paddr == nsov_pkg::STATUS_OFS);
	wire         hit_volt   = (paddr == nsov_pkg::VOLTAGE_OFS);
	wire         mapped     = hit_ctrl | hit_pct | hit_delay | hit_status
	                        | hit_volt;
	wire         ro_hit     = hit_status | hit_volt;
	wire [15:0]  pct_wr     = clamp16({8'h00, pwdata[7:0]},
	                                  {8'h00, nsov_pkg::PCT_MIN},
	                                  {8'h00, nsov_pkg::PCT_MAX});
	wire [15:0]  delay_wr   = clamp16(pwdata[15:0], nsov_pkg::DELAY_MIN,
	                                  nsov_pkg::DELAY_MAX);

	wire         st_start   = (state_q != nsov_pkg::NSOV_IDLE);
	wire         st_trip    = (state_q == nsov_pkg::NSOV_TRIPPED);
	wire [31:0]  status_rd  = {28'h000_0000, gtrip_q, gstart_q, st_trip,
	                           st_start};
	wire [31:0]  ctrl_rd    = {30'h000_0000, cfg_q.start_only,
	                           cfg_q.enable};
	wire [31:0]  rd_mux     = hit_ctrl   ? ctrl_rd :
	                          hit_pct    ? {24'h00_0000, cfg_q.pct} :
	                          hit_delay  ? {16'h0000, cfg_q.delay} :
	                          hit_status ? status_rd :
	                          hit_volt   ? {16'h0000, neg_seq_voltage} :
	                          32'h0000_0000;

	// Read data is captured in the setup cycle, so a status read shows the
	// state one cycle before the access phase; that skew is accepted to
	// keep every output of the block straight from a flip-flop.
	// Writes to read-only or unmapped words raise pslverr and change
	// nothing; reads of unmapped words return zero with the same error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup_cyc;
			pslverr_q <= setup_cyc & (~mapped | (pwrite & ro_hit));
			if (setup_cyc & ~pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q.enable     <= nsov_pkg::ENABLE_RESET;
			cfg_q.start_only <= nsov_pkg::SONLY_RESET;
			cfg_q.pct        <= nsov_pkg::PCT_RESET;
			cfg_q.delay      <= nsov_pkg::DELAY_RESET;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				cfg_q.enable     <= pwdata[nsov_pkg::CTRL_ENABLE_BIT];
				cfg_q.start_only <= pwdata[nsov_pkg::CTRL_SONLY_BIT];
			end
			if (hit_pct) begin
				cfg_q.pct <= pct_wr[7:0];
			end
			if (hit_delay) begin
				cfg_q.delay <= delay_wr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Definite time characteristic. Strict greater-than keeps a voltage
	// sitting exactly on the threshold from chattering the start status.
	// The threshold is the whole percent setting placed above the
	// fraction bits of the voltage input, so both sides share one scale.

	wire [15:0]  thresh     = {cfg_q.pct, {nsov_pkg::VOLT_FRAC_BITS{1'b0}}};
	wire         over_v     = (neg_seq_voltage > thresh);
	wire         active     = cfg_q.enable & ~function_block_in;
	// The prescaler counts clock cycles up to one millisecond.
	wire         tick_last  = (tick_cnt_q == 32'(MS_TICK_CYCLES - 1));
	wire         delay_done = (ms_cnt_q >= cfg_q.delay);

	// Start and trip statuses are decoded from this one state machine,
	// so trip can never be reported without start.
	always_comb begin
		state_d = state_q;
		case (state_q)
			nsov_pkg::NSOV_IDLE: begin
				if (over_v & active) begin
					state_d = nsov_pkg::NSOV_STARTED;
				end
			end
			nsov_pkg::NSOV_STARTED: begin
				if (~over_v | ~active) begin
					state_d = nsov_pkg::NSOV_IDLE;
				end else if (delay_done) begin
					state_d = nsov_pkg::NSOV_TRIPPED;
				end
			end
			nsov_pkg::NSOV_TRIPPED: begin
				if (~over_v | ~active) begin
					state_d = nsov_pkg::NSOV_IDLE;
				end
			end
			default: begin
				state_d = nsov_pkg::NSOV_IDLE;
			end
		endcase
	end

	// The millisecond prescaler restarts with each start, so the delay is
	// measured from the start edge and not from a free-running tick.
	// Both counters hold at zero outside the started state.
	// Limitation: the operate time adds about two clock cycles of decision
	// latency to the set delay, far below one millisecond at this clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= nsov_pkg::NSOV_IDLE;
			tick_cnt_q <= 32'h0000_0000;
			ms_cnt_q   <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_d != nsov_pkg::NSOV_STARTED) begin
				tick_cnt_q <= 32'h0000_0000;
				ms_cnt_q   <= 16'h0000;
			end else if (tick_last) begin
				tick_cnt_q <= 32'h0000_0000;
				ms_cnt_q   <= ms_cnt_q + 16'h0001;
			end else begin
				tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decision logic.
	// Start-only mode gates only the general trip output; the internal
	// trip status stays readable in the status word for diagnosis.
	// Disabling, by the enable bit or the block input, gates both outputs.

	wire         gstart_d   = st_start & active;
	wire         gtrip_d    = st_trip & active & ~cfg_q.start_only;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gstart_q <= 1'b0;
			gtrip_q  <= 1'b0;
		end else begin
			gstart_q <= gstart_d;
			gtrip_q  <= gtrip_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop.

	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign general_start_out = gstart_q;
	assign general_trip_out  = gtrip_q;

endmodule

/* test/nsov_checker.sv */
`timescale 1ns/1ps
module nsov_checker #(
	parameter int MS_TICK_CYCLES = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] neg_seq_voltage,
	input wire logic        function_block_in,
	input wire logic        general_start_out,
	input wire logic        general_trip_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	int run_q;
	// Counts how long general start has stood, to bound the earliest trip.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) run_q <= 0;
		else run_q <= general_start_out ? run_q + 1 : 0;
	end
	sequence setup_s; psel && !penable; endsequence
	sequence quiet_s; neg_seq_voltage <= 16'h0200; endsequence
	block_kills_a: assert property (function_block_in |-> ##2
		!general_start_out && !general_trip_out) else $error("block ignored");
	low_volt_drop_a: assert property (quiet_s |-> ##2
		!general_start_out) else $error("start held at low voltage");
	start_cause_a: assert property ($rose(general_start_out) |->
		$past(neg_seq_voltage, 2) > 16'h0200) else $error("start no cause");
	trip_start_a: assert property (general_trip_out |->
		general_start_out) else $error("trip without start");
	trip_gap_a: assert property ($rose(general_trip_out) |->
		run_q >= 50 * MS_TICK_CYCLES - 2) else $error("trip too early");
	ready_once_a: assert property (pready |=> !pready)
		else $error("pready held");
	ready_setup_a: assert property (setup_s |=> pready)
		else $error("no pready after setup");
	unmapped_err_a: assert property (setup_s and paddr >= 8'h14 |=>
		pslverr) else $error("unmapped without error");
	ro_write_err_a: assert property (setup_s and pwrite and
		paddr == nsov_pkg::STATUS_OFS |=> pslverr) else $error("ro write");
endmodule
bind nsov_trip nsov_checker #(
	.MS_TICK_CYCLES(MS_TICK_CYCLES)
) chk (
	.pclk              (pclk),
	.presetn           (presetn),
	.psel              (psel),
	.penable           (penable),
	.pwrite            (pwrite),
	.paddr             (paddr),
	.pready            (pready),
	.pslverr           (pslverr),
	.neg_seq_voltage   (neg_seq_voltage),
	.function_block_in (function_block_in),
	.general_start_out (general_start_out),
	.general_trip_out  (general_trip_out)
);

/* test/nsov_upstream.sv */
`timescale 1ns/1ps
// Upstream sequence calculation stand-in, one sample of latency.
module nsov_upstream (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] target,
	output logic      [15:0] neg_seq_voltage
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) neg_seq_voltage <= 16'h0000;
		else neg_seq_voltage <= target;
	end
endmodule

/* test/neg_seq_overvoltage_trip_bench.sv */
`timescale 1ns/1ps
module neg_seq_overvoltage_trip_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, function_block_in = 0;
	logic general_start_out, general_trip_out;
	logic [15:0] target = 0, neg_seq_voltage;
	int bad_count = 0, tests_run = 0, cyc = 0, n;
	nsov_trip #(
		.MS_TICK_CYCLES(4)
	) dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.neg_seq_voltage   (neg_seq_voltage),
		.function_block_in (function_block_in),
		.general_start_out (general_start_out),
		.general_trip_out  (general_trip_out)
	);
	nsov_upstream up (.pclk, .presetn, .target, .neg_seq_voltage);
	always #2 pclk = ~pclk;
	// Whole run needs about 660 cycles; the ceiling leaves ample margin.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict;
		end
	end
	task give_verdict;
		if (bad_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] er, input logic ee);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		if (!w) check(prdata, er);
		check(pslverr, ee);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task t_regs;
		acc(0, nsov_pkg::CTRL_OFS, 0, 1, 0);
		acc(0, nsov_pkg::START_PCT_OFS, 0, 8'h1e, 0);
		acc(0, nsov_pkg::TRIP_DELAY_OFS, 0, 16'h0064, 0);
		acc(1, nsov_pkg::STATUS_OFS, 5, 0, 1);
		acc(0, 8'h20, 0, 0, 1);
		acc(1, nsov_pkg::START_PCT_OFS, 1, 0, 0);
		acc(0, nsov_pkg::START_PCT_OFS, 0, 2, 0);
		acc(1, nsov_pkg::START_PCT_OFS, 8'h50, 0, 0);
		acc(0, nsov_pkg::START_PCT_OFS, 0, 8'h28, 0);
		acc(1, nsov_pkg::TRIP_DELAY_OFS, 16'hffff, 0, 0);
		acc(0, nsov_pkg::TRIP_DELAY_OFS, 0, 16'hea60, 0);
		acc(1, nsov_pkg::TRIP_DELAY_OFS, 8'h0a, 0, 0);
		acc(0, nsov_pkg::TRIP_DELAY_OFS, 0, 8'h32, 0);
		acc(1, nsov_pkg::START_PCT_OFS, 8'h0a, 0, 0);
	endtask
	task t_trip;
		target <= 16'h0a00;
		repeat (20) @(posedge pclk);
		check(general_start_out, 0);
		target <= 16'h0a01;
		repeat (5) @(posedge pclk);
		check(general_start_out, 1);
		n = 0;
		while (general_trip_out !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		check(n >= 190 && n <= 210, 1);
		function_block_in <= 1;
		repeat (3) @(posedge pclk);
		check({general_start_out, general_trip_out}, 0);
		function_block_in <= 0;
		repeat (100) @(posedge pclk);
		check({general_start_out, general_trip_out}, 2);
		acc(1, nsov_pkg::CTRL_OFS, 3, 0, 0);
		repeat (250) @(posedge pclk);
		check({general_start_out, general_trip_out}, 2);
		acc(0, nsov_pkg::STATUS_OFS, 0, 32'h0000_0007, 0);
		acc(0, nsov_pkg::VOLTAGE_OFS, 0, 32'h0000_0a01, 0);
		acc(1, nsov_pkg::CTRL_OFS, 0, 0, 0);
		repeat (3) @(posedge pclk);
		check({general_start_out, general_trip_out}, 0);
	endtask
	// A second reset in mid-run must restore every setting.
	task t_reset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check({general_start_out, general_trip_out}, 0);
		acc(0, nsov_pkg::CTRL_OFS, 0, 1, 0);
		acc(0, nsov_pkg::START_PCT_OFS, 0, 8'h1e, 0);
		acc(0, nsov_pkg::TRIP_DELAY_OFS, 0, 16'h0064, 0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_trip;
		t_reset;
		give_verdict;
	end
endmodule
